/* dv/ctm_src.sv */
// signal source stand-in: square pulses on the signal pin
// assumes hi/lo widths in reference clock cycles
`timescale 1ns/1ps
module ctm_src (
   // timing
   input  wire logic       clk_in,
   // pulse control
   input  wire logic       en_in,
   input  wire logic [7:0] hi_in,
   input  wire logic [7:0] lo_in,
   // signal pin
   output logic            sig_out
);
   // a started pulse always finishes, so none is cut below the filter
   initial begin
      sig_out = 1'b0;
      forever begin
         @(negedge clk_in);
         if (en_in) begin
            sig_out = 1'b1;
            repeat (hi_in) @(negedge clk_in);
            sig_out = 1'b0;
            repeat (lo_in - 8'h01) @(negedge clk_in);
         end
      end
   end
endmodule : ctm_src

/* dv/testbench.sv */
// self-checking bench for the counter/timer control block
// assumes short gate parameters; pll pin looped back from the reference output
`timescale 1ns/1ps
module testbench;
   import ctm_pkg::*;
   logic        clk, rstn, wr, rd, btn, en, sig, pll_ref, gate, ovf, mact, rear;
   logic [1:0]  ext_cnt;
   logic [7:0]  addr, hi, lo;
   logic [31:0] wdata, rdata, v;
   ctm_disp_s   disp;
   int          bad_count, cmp_count, n_edges, m;

   ctm_top #(.GATE_TK0(32'd20), .GATE_TK1(32'd40), .GATE_TK2(32'd60),
      .GATE_TK3(32'd80), .LB_SLOW_CYC(21'd3000)) DUT (
      .ref_clk_in(clk), .resetn_in(rstn), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .front_sig_in(sig && !rear),
      .rear_sig_in(sig && rear), .ext_ref_in(ext_cnt[1]), .pll_sig_in(pll_ref),
      .reset_btn_in(btn), .pll_ref_out(pll_ref), .disp_out(disp),
      .gate_out(gate), .overflow_out(ovf), .mult_active_out(mact));
   ctm_src SRC (.clk_in(clk), .en_in(en), .hi_in(hi), .lo_in(lo), .sig_out(sig));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge sig) n_edges++;

   // external time base stand-in: one rise every four clocks
   always @(posedge clk) ext_cnt <= ext_cnt + 2'd1;

   task automatic chk(input string name, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   function automatic logic [31:0] bcd(input int n);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 6; i++) begin
         r[i*4 +: 4] = 4'(n % 10);
         n = n / 10;
      end
      return r;
   endfunction : bcd

   task automatic wait_gate(inout int i);
      @(negedge clk);
      while (gate !== 1'b1 && i < 3000) begin
         @(negedge clk);
         i++;
      end
      while (gate !== 1'b0 && i < 3000) begin
         @(negedge clk);
         i++;
      end
   endtask : wait_gate

   // frequency modes restart the source right after a gate closes, so the
   // next gate holds whole periods whatever the tick phase; time modes open
   // on the first leading edge of the source
   task automatic meas(input logic [31:0] c, e);
      int i;
      i = 0;
      @(posedge clk);
      en <= 1'b0;
      wr_reg(8'h00, c);
      cyc(40);
      if (c[2:0] < 3'd2) wait_gate(i);
      @(posedge clk);
      en <= 1'b1;
      wait_gate(i);
      @(posedge clk);
      en <= 1'b0;
      chk("gate wait", 0, (i >= 3000));
      cyc(4);
      rd_reg(8'h08, v);
      chk("result", e, v);
   endtask : meas

   task automatic t_reset();
      rd_reg(8'h00, v);
      chk("ctrl reset", 32'h0a0, v);
      rd_reg(8'h0c, v);
      chk("unmapped", 32'h0, v);
      rd_reg(8'h08, v);
      chk("result reset", 32'h0, v);
   endtask : t_reset

   task automatic t_freq();
      meas(32'h000, 32'h5);
      rd_reg(8'h04, v);
      chk("dp direct", 32'h1, {29'h0, v[6:4]});
      chk("mult lamp", 32'h0, {31'h0, mact});
      meas(32'h019, 32'h2);
      rd_reg(8'h04, v);
      chk("dp prescaled", 32'h3, {29'h0, v[6:4]});
   endtask : t_freq

   task automatic t_time();
      @(posedge clk);
      hi <= 8'h07;
      lo <= 8'h09;
      meas(32'h003, 32'h3);
      meas(32'h004, 32'h4);
      meas(32'h00a, 32'h80);
      meas(32'h002, 32'h8);
      cyc(20);
      rear <= 1'b1;
      meas(32'h202, 32'h8);
      cyc(20);
      rear <= 1'b0;
      meas(32'h102, 32'h4);
   endtask : t_time

   task automatic t_hold();
      logic seen;
      seen = 1'b0;
      wr_reg(8'h00, 32'h042);
      en <= 1'b1;
      cyc(40);
      hi <= 8'h04;
      lo <= 8'h04;
      repeat (300) begin
         @(negedge clk);
         if (gate !== 1'b0) seen = 1'b1;
      end
      chk("gate in hold", 32'h0, {31'h0, seen});
      rd_reg(8'h08, v);
      chk("held result", 32'h8, v);
   endtask : t_hold

   task automatic t_accum();
      @(posedge clk);
      en <= 1'b0;
      cyc(20);
      wr_reg(8'h00, 32'h005);
      btn <= 1'b1;
      cyc(8);
      chk("lamp test", 32'h888888, {8'h0, disp.digit});
      btn <= 1'b0;
      cyc(8);
      chk("cleared", 32'h0, {8'h0, disp.digit});
      n_edges = 0;
      en <= 1'b1;
      cyc(100);
      en <= 1'b0;
      cyc(30);
      m = n_edges;
      rd_reg(8'h08, v);
      chk("total", bcd(m), v);
      chk("ovf lamp", 32'h0, {31'h0, ovf});
      wr_reg(8'h00, 32'h045);
      en <= 1'b1;
      cyc(100);
      en <= 1'b0;
      cyc(30);
      rd_reg(8'h08, v);
      chk("frozen", bcd(m), v);
      wr_reg(8'h00, 32'h005);
      rd_reg(8'h08, v);
      chk("refreshed", bcd(n_edges), v);
   endtask : t_accum

   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   initial begin
      #1000000;
      bad_count++;
      $display("BAD watchdog expired");
      conclude();
   end

   initial begin
      {rstn, wr, rd, btn, en, rear, ext_cnt, addr, wdata} = '0;
      hi = 8'h04;
      lo = 8'h04;
      cyc(10);
      rstn <= 1'b1;
      t_reset();
      t_freq();
      t_time();
      t_hold();
      t_accum();
      conclude();
   end
endmodule : testbench

/* rtl/ctm_bcd6.sv */
// six-digit decimal counting register with sticky overflow
// clear and increment come from the same clock domain
`timescale 1ns/1ps
`include "ctm_defs.svh"
module ctm_bcd6 (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   // control
   input  wire logic       clr_in,
   input  wire logic       inc_in,
   // count state
   output logic [5:0][3:0] dig_out,
   output logic            ovf_out
);
   logic [6:0] carry;

   assign carry[0] = inc_in;

   for (genvar i = 0; i < 6; i++) begin : g_dig
      assign carry[i+1] = carry[i] && (dig_out[i] == `CTM_BCD_MAX);
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) dig_out[i] <= 4'h0;
         else if (clr_in) dig_out[i] <= 4'h0;
         else if (carry[i+1]) dig_out[i] <= 4'h0;
         else if (carry[i]) dig_out[i] <= dig_out[i] + 4'h1;
      end
   end

   // carry out of the top digit wins over a clear in the same cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) ovf_out <= 1'b0;
      else ovf_out <= carry[6] || (ovf_out && !clr_in);
   end
endmodule : ctm_bcd6

/* rtl/ctm_defs.svh */
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz reference clock
`ifndef CTM_DEFS_SVH
`define CTM_DEFS_SVH
`define CTM_CTRL_OFF 8'h00
`define CTM_STAT_OFF 8'h04
`define CTM_RES_OFF 8'h08
`define CTM_CTRL_W 10
`define CTM_CTRL_RST 10'h0a0
`define CTM_ST_GATE 0
`define CTM_ST_OVF 1
`define CTM_ST_MACT 2
`define CTM_ST_LBAND 3
`define CTM_ST_DP 4
`define CTM_ST_BLANK 8
`define CTM_CLK_NS 50
`define CTM_TICK_NS 100
`define CTM_TICK_CYC (`CTM_TICK_NS / `CTM_CLK_NS)
`define CTM_LB_FAST_NS 40000
`define CTM_LB_SLOW_NS 100000000
`define CTM_LB_FAST_CYC ((`CTM_LB_FAST_NS + `CTM_CLK_NS - 1) / `CTM_CLK_NS)
`define CTM_LB_SLOW_CYC (`CTM_LB_SLOW_NS / `CTM_CLK_NS)
`define CTM_GATE_US0 64'd10000
`define CTM_GATE_US1 64'd100000
`define CTM_GATE_US2 64'd1000000
`define CTM_GATE_US3 64'd10000000
`define CTM_GATE_TK(us) ((us) * 64'd1000 / `CTM_TICK_NS)
`define CTM_AVG0 10'd1
`define CTM_AVG1 10'd10
`define CTM_AVG2 10'd100
`define CTM_AVG3 10'd1000
`define CTM_PSC_DIV 4'd10
`define CTM_MULT_DIGITS 3'd2
`define CTM_BCD_MAX 4'h9
`define CTM_LAMP_ALL 24'h888888
`endif

/* rtl/ctm_pkg.sv */
// types shared by the counter/timer control files
// no assumptions beyond the constants header
package ctm_pkg;
   typedef enum logic [2:0] {
      direct_frequency_mode,
      prescaled_frequency_mode,
      period_mode,
      pos_width_mode,
      neg_width_mode,
      pulse_accumulate_mode
   } ctm_func_e;

   typedef enum logic [2:0] {
      st_idle, st_arm, st_open, st_xfer, st_accum
   } ctm_state_e;

   typedef struct packed {
      logic       rear_in;
      logic       ext_tb;
      logic       mult_en;
      logic       hold;
      logic       auto_sel;
      logic [1:0] interval_selector;
      ctm_func_e  func;
   } ctm_ctrl_s;

   typedef struct packed {
      logic [5:0][3:0] digit;
      logic [5:0]      blank;
      logic [2:0]      dp;
      logic            ovf;
   } ctm_disp_s;
endpackage : ctm_pkg

/* rtl/ctm_sync.sv */
// three-stage synchroniser with agreement filter, one per bit
// inputs come from pins outside the reference clock domain
`timescale 1ns/1ps
module ctm_sync #(
   parameter int W = 1
)(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         resetn_in,
   // pins and filtered levels
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] s1_q, s2_q, s3_q;

   for (genvar i = 0; i < W; i++) begin : g_bit
      // a change counts only once stages two and three agree
      always_ff @(posedge clk_in or negedge resetn_in) begin
         if (!resetn_in) begin
            s1_q[i]  <= 1'b0;
            s2_q[i]  <= 1'b0;
            s3_q[i]  <= 1'b0;
            q_out[i] <= 1'b0;
         end else begin
            s1_q[i] <= d_in[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) q_out[i] <= s3_q[i];
         end
      end
   end
endmodule : ctm_sync

/* rtl/ctm_top.sv */
// measurement control of a six-digit counter/timer
// assumes conditioned logic-level inputs and a 20 MHz reference clock;
// the phase-locked x100 multiplier itself sits outside and returns pll_sig_in
//
// How it works
// - six-digit readout, automatic decimal point, leading zeros blanked
// - gate lamp lit while the measurement gate is open and throughout accumulate mode
// - overflow lamp lit when the count exceeds the registers
// - low band 10 Hz to 25 kHz engages the x100 multiplier in direct mode
// - multiplier lamp follows the path chosen when each gate arms, held until the next arming, a reset or a non-frequency mode
// - direct mode counts input cycles with no prescaling
// - prescaled mode divides the input by ten before counting
// - period mode times between successive rising trigger points
// - positive width times rising edge to following falling edge
// - negative width times falling edge to following rising edge
// - accumulate mode shows a running total until reset; overflow lights the lamp and the count wraps on
// - interval selector sets gate time or averages by function
// - automatic setting picks the gate giving a full six digits
// - reset zeroes the total and clears the readout
// - reset held shows eight on every digit
// - run repeats measurements or counts continuously
// - hold keeps last result and starts no new measurement
// - hold in accumulate freezes readout, counting goes on
// - hold release in accumulate refreshes readout at once
// - external reference clock may replace the internal time base
// - rear signal input may replace the front input
// - multiplier enabled after reset, may be disabled by software
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ctm_defs.svh"
module ctm_top import ctm_pkg::*; #(
   parameter logic [31:0] GATE_TK0    = 32'(`CTM_GATE_TK(`CTM_GATE_US0)),
   parameter logic [31:0] GATE_TK1    = 32'(`CTM_GATE_TK(`CTM_GATE_US1)),
   parameter logic [31:0] GATE_TK2    = 32'(`CTM_GATE_TK(`CTM_GATE_US2)),
   parameter logic [31:0] GATE_TK3    = 32'(`CTM_GATE_TK(`CTM_GATE_US3)),
   parameter logic [20:0] LB_SLOW_CYC = 21'(`CTM_LB_SLOW_CYC)
)(
   // clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // signal and panel pins
   input  wire logic        front_sig_in,
   input  wire logic        rear_sig_in,
   input  wire logic        ext_ref_in,
   input  wire logic        pll_sig_in,
   input  wire logic        reset_btn_in,
   // indicators and readout
   output logic             pll_ref_out,
   output ctm_disp_s        disp_out,
   output logic             gate_out,
   output logic             overflow_out,
   output logic             mult_active_out
);
   ctm_ctrl_s       ctrl_q;
   ctm_state_e      st_q, st_d;
   ctm_func_e       func_q;
   logic [4:0]      syn;
   logic            sig_p_q, pll_p_q, ext_p_q;
   logic [3:0]      div_q, psc_q;
   logic [20:0]     per_q;
   logic            lband_q, mult_q, lamp_q;
   logic [31:0]     tmr_q;
   logic [9:0]      nev_q;
   logic [1:0]      aidx_q;
   logic [5:0][3:0] dig_q, cnt_dig;
   logic [5:0]      blank_q, lz;
   logic [2:0]      dp_q;
   logic            ovf_q, cnt_ovf;
   logic [31:0]     rdata_q;

   // pin conditioning; front or rear signal after the filter
   ctm_sync #(.W(5)) u_sync (
      .clk_in    (ref_clk_in),
      .resetn_in (resetn_in),
      .d_in      ({reset_btn_in, pll_sig_in, ext_ref_in, rear_sig_in, front_sig_in}),
      .q_out     (syn)
   );

   wire sig      = ctrl_q.rear_in ? syn[1] : syn[0];
   wire btn      = syn[4];
   wire sig_rise = sig && !sig_p_q;
   wire sig_fall = !sig && sig_p_q;
   wire pll_rise = syn[3] && !pll_p_q;
   wire ext_rise = syn[2] && !ext_p_q;

   assign pll_ref_out = sig;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sig_p_q <= 1'b0;
         pll_p_q <= 1'b0;
         ext_p_q <= 1'b0;
      end else begin
         sig_p_q <= sig;
         pll_p_q <= syn[3];
         ext_p_q <= syn[2];
      end
   end

   // time base: 100 ns ticks from the divider or the outside reference
   wire int_tick = div_q == 4'(`CTM_TICK_CYC - 1);
   wire tick     = ctrl_q.ext_tb ? ext_rise : int_tick;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) div_q <= 4'h0;
      else div_q <= int_tick ? 4'h0 : div_q + 4'h1;
   end

   // divide-by-ten prescaler for the high band
   wire psc_wrap = sig_rise && (psc_q == `CTM_PSC_DIV - 4'd1);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) psc_q <= 4'h0;
      else if (psc_wrap) psc_q <= 4'h0;
      else if (sig_rise) psc_q <= psc_q + 4'h1;
   end

   // low-band detect from the input period in reference cycles
   wire per_sat  = per_q == 21'h1fffff;
   wire per_band = (per_q >= 21'(`CTM_LB_FAST_CYC)) && (per_q <= LB_SLOW_CYC);

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         per_q   <= 21'h0;
         lband_q <= 1'b0;
      end else if (sig_rise) begin
         per_q   <= 21'h0;
         lband_q <= per_band;
      end else begin
         per_q <= per_sat ? per_q : per_q + 21'h1;
         if (per_q > LB_SLOW_CYC) lband_q <= 1'b0;
      end
   end

   wire mult_sel = (ctrl_q.func == direct_frequency_mode) && ctrl_q.mult_en
                   && lband_q;

   // mode decode
   wire is_freq  = (ctrl_q.func == direct_frequency_mode)
                   || (ctrl_q.func == prescaled_frequency_mode);
   wire is_width = (ctrl_q.func == pos_width_mode) || (ctrl_q.func == neg_width_mode);
   wire is_per   = ctrl_q.func == period_mode;
   wire is_acc   = ctrl_q.func == pulse_accumulate_mode;
   wire is_meas  = is_freq || is_width || is_per;
   wire func_chg = ctrl_q.func != func_q;

   // width edges by polarity
   wire w_pos   = ctrl_q.func == pos_width_mode;
   wire w_lead  = w_pos ? sig_rise : sig_fall;
   wire w_trail = w_pos ? sig_fall : sig_rise;
   wire w_act   = w_pos ? sig : !sig;

   // interval selector reading: gate time or averages
   wire [1:0] idx = (ctrl_q.auto_sel && is_freq) ? aidx_q
                    : (ctrl_q.auto_sel ? 2'd0 : ctrl_q.interval_selector);

   logic [31:0] gate_len;
   logic [9:0]  avg_n;
   assign gate_len = (idx == 2'd0) ? GATE_TK0 :
                     (idx == 2'd1) ? GATE_TK1 :
                     (idx == 2'd2) ? GATE_TK2 : GATE_TK3;
   assign avg_n    = (idx == 2'd0) ? `CTM_AVG0 :
                     (idx == 2'd1) ? `CTM_AVG1 :
                     (idx == 2'd2) ? `CTM_AVG2 : `CTM_AVG3;

   wire gate_end = tick && (tmr_q == gate_len - 32'd1);
   wire avg_end  = nev_q == avg_n - 10'd1;

   // count source per mode
   wire freq_edge = (ctrl_q.func == prescaled_frequency_mode) ? psc_wrap
                    : (mult_q ? pll_rise : sig_rise);
   logic cnt_inc;
   assign cnt_inc = (st_q == st_accum) ? sig_rise :
                    (st_q != st_open) ? 1'b0 :
                    is_freq ? freq_edge :
                    is_per ? tick :
                    (tick && w_act);

   wire start_ok = !btn && !(ctrl_q.hold && is_meas);
   wire cnt_clr  = btn || func_chg || ((st_q == st_idle) && start_ok);

   ctm_bcd6 u_cnt (
      .clk_in    (ref_clk_in),
      .resetn_in (resetn_in),
      .clr_in    (cnt_clr),
      .inc_in    (cnt_inc),
      .dig_out   (cnt_dig),
      .ovf_out   (cnt_ovf)
   );

   // gate sequencer
   always_comb begin
      st_d = st_q;
      case (st_q)
         st_idle: begin
            if (start_ok && is_acc) st_d = st_accum;
            else if (start_ok && is_meas) st_d = st_arm;
         end
         st_arm: begin
            if (is_freq) st_d = st_open;
            else if (is_per && sig_rise) st_d = st_open;
            else if (is_width && w_lead) st_d = st_open;
         end
         st_open: begin
            if (is_freq && gate_end) st_d = st_xfer;
            else if (is_per && sig_rise && avg_end) st_d = st_xfer;
            else if (is_width && w_trail && avg_end) st_d = st_xfer;
         end
         st_xfer: st_d = st_idle;
         st_accum: st_d = st_accum;
         default: st_d = st_idle;
      endcase
      if (btn || func_chg) st_d = st_idle;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q   <= st_idle;
         func_q <= direct_frequency_mode;
      end else begin
         st_q   <= st_d;
         func_q <= ctrl_q.func;
      end
   end

   // gate timer and averaged-event counter
   wire evt = is_per ? sig_rise : w_trail;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tmr_q <= 32'h0;
         nev_q <= 10'h0;
      end else if (st_q != st_open) begin
         tmr_q <= 32'h0;
         nev_q <= 10'h0;
      end else begin
         if (tick) tmr_q <= tmr_q + 32'h1;
         if (evt) nev_q <= nev_q + 10'h1;
      end
   end

   // multiplier path fixed for a whole gate so one count never mixes sources
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) mult_q <= 1'b0;
      else if (!is_freq || btn) mult_q <= 1'b0;
      else if (st_q == st_arm) mult_q <= mult_sel;
   end

   // automatic gate: shorter on overflow, longer while the top digit is empty
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) aidx_q <= 2'd0;
      else if (st_q == st_xfer && is_freq) begin
         if (cnt_ovf && aidx_q != 2'd0) aidx_q <= aidx_q - 2'd1;
         else if (!cnt_ovf && cnt_dig[5] == 4'h0 && aidx_q != 2'd3)
            aidx_q <= aidx_q + 2'd1;
      end
   end

   // decimal places of the result in kHz or microseconds
   logic [2:0] dec;
   assign dec = (ctrl_q.func == direct_frequency_mode)
                ? 3'(3'd1 + 3'(idx) + (mult_q ? `CTM_MULT_DIGITS : 3'd0)) :
                (ctrl_q.func == prescaled_frequency_mode) ? 3'(idx) :
                (is_per || is_width) ? 3'(3'd1 + 3'(idx)) : 3'd0;

   // readout register
   wire acc_live = (st_q == st_accum) && !ctrl_q.hold;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dig_q  <= 24'h0;
         dp_q   <= 3'd0;
         ovf_q  <= 1'b0;
         lamp_q <= 1'b0;
      end else if (btn) begin
         dig_q  <= `CTM_LAMP_ALL;
         ovf_q  <= 1'b0;
         lamp_q <= 1'b1;
      end else if (lamp_q) begin
         dig_q  <= 24'h0;
         dp_q   <= 3'd0;
         lamp_q <= 1'b0;
      end else if (st_q == st_xfer || acc_live) begin
         dig_q <= cnt_dig;
         dp_q  <= dec;
         ovf_q <= cnt_ovf;
      end
   end

   // leading-zero blanking, never at or right of the decimal point
   assign lz[5] = dig_q[5] == 4'h0;
   for (genvar i = 0; i < 5; i++) begin : g_lz
      assign lz[i] = lz[i+1] && (dig_q[i] == 4'h0);
   end

   logic [5:0] blank_d;
   for (genvar i = 0; i < 6; i++) begin : g_blank
      assign blank_d[i] = lz[i] && (i > 0) && (3'(i) > dp_q) && !lamp_q;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) blank_q <= 6'h3e;
      else blank_q <= blank_d;
   end

   assign disp_out        = {dig_q, blank_q, dp_q, ovf_q};
   assign gate_out        = (st_q == st_open) || (st_q == st_accum);
   assign overflow_out    = ovf_q;
   assign mult_active_out = mult_q;

   // register port
   wire sel_ctrl = addr_in == `CTM_CTRL_OFF;
   wire sel_stat = addr_in == `CTM_STAT_OFF;
   wire sel_res  = addr_in == `CTM_RES_OFF;

   logic [31:0] stat_w, rd_mux;
   always_comb begin
      stat_w = 32'h0;
      stat_w[`CTM_ST_GATE]  = gate_out;
      stat_w[`CTM_ST_OVF]   = ovf_q;
      stat_w[`CTM_ST_MACT]  = mult_q;
      stat_w[`CTM_ST_LBAND] = lband_q;
      stat_w[`CTM_ST_DP +: 3]    = dp_q;
      stat_w[`CTM_ST_BLANK +: 6] = blank_q;
   end

   assign rd_mux = sel_ctrl ? {22'h0, ctrl_q} :
                   sel_stat ? stat_w :
                   sel_res ? {8'h0, dig_q} : 32'h0;

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) ctrl_q <= ctm_ctrl_s'(`CTM_CTRL_RST);
      else if (wr_in && sel_ctrl) ctrl_q <= ctm_ctrl_s'(wdata_in[`CTM_CTRL_W-1:0]);
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) rdata_q <= 32'h0;
      else if (rd_in) rdata_q <= rd_mux;
   end

   assign rdata_out = rdata_q;

   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_close;
      (st_q == st_open) ##1 (st_q == st_xfer);
   endsequence
   sequence s_btn_release;
      btn ##1 !btn;
   endsequence
   sequence s_acc_held;
      (st_q == st_accum && ctrl_q.hold && !btn)[*2];
   endsequence

   property p_gate_close;
      s_close |-> !gate_out && $past(gate_out);
   endproperty
   a_gate_close: assert property (p_gate_close)
      else $error("gate lamp not dropped at gate close");

   property p_ovf_shown;
      (st_q == st_xfer && cnt_ovf && !btn) |=> overflow_out;
   endproperty
   a_ovf_shown: assert property (p_ovf_shown)
      else $error("overflow not shown after transfer");

   property p_mult_off;
      (st_q == st_arm && !ctrl_q.mult_en) |=> !mult_active_out;
   endproperty
   a_mult_off: assert property (p_mult_off)
      else $error("multiplier active while disabled");

   property p_lamp;
      btn |=> dig_q == `CTM_LAMP_ALL;
   endproperty
   a_lamp: assert property (p_lamp)
      else $error("lamp test digits not all eight");

   property p_clear;
      s_btn_release |=> dig_q == 24'h0 && cnt_dig == 24'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("readout not cleared after reset button");

   property p_hold;
      (st_q == st_idle && ctrl_q.hold && is_meas && !btn) |=> st_q == st_idle;
   endproperty
   a_hold: assert property (p_hold)
      else $error("measurement started while held");

   property p_xfer;
      (st_q == st_xfer && !btn && !lamp_q) |=> dig_q == $past(cnt_dig);
   endproperty
   a_xfer: assert property (p_xfer)
      else $error("readout not loaded at gate close");

   property p_acc_freeze;
      s_acc_held |-> $stable(dig_q);
   endproperty
   a_acc_freeze: assert property (p_acc_freeze)
      else $error("accumulate readout moved while held");

   property p_acc_live;
      (st_q == st_accum && !ctrl_q.hold && !btn && !lamp_q) |=> dig_q == $past(cnt_dig);
   endproperty
   a_acc_live: assert property (p_acc_live)
      else $error("accumulate readout not live in run");

   property p_acc_counts;
      (st_q == st_accum && ctrl_q.hold && sig_rise && !btn && !func_chg
       && cnt_dig[0] != `CTM_BCD_MAX) |=> cnt_dig[0] == 4'($past(cnt_dig[0]) + 4'h1);
   endproperty
   a_acc_counts: assert property (p_acc_counts)
      else $error("count stopped during hold");
endmodule : ctm_top
